// File: hdl/rail_offset_pwm_timing_config.sv
`timescale 1ns/100ps
`include "rail_defines.svh"

module rail_offset_pwm_timing_config (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [7:0] cmd_code_in,
    input  wire logic       cmd_wr_in,
    input  wire logic       cmd_rd_in,
    input  wire logic [15:0] cmd_wdata_in,
    input  wire logic [1:0] vid_mode_in,
    input  wire logic [7:0] initial_vid_in,
    input  wire logic       overshoot_detect_in,
    input  wire logic       dual_phase_in,
    input  wire logic       two_phase_ccm_in,
    input  wire logic [1:0] pwm_req_in,
    input  wire logic [5:0] other_slope_current_in,
    input  wire logic [3:0] other_slope_cap_in,
    output logic [15:0]     cmd_rdata_out,
    output logic [9:0]      target_vid_out,
    output logic            osr_flag_out,
    output logic [1:0]      pwm_pulse_out,
    output logic            slope_start_out,
    output logic            slope_clamp_out,
    output logic [5:0]      slope_current_out,
    output logic [3:0]      slope_cap_out
);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [15:0] offsets_reg,  offsets_next;
    logic [15:0] osr_reg,      osr_next;
    logic [15:0] blank_reg,    blank_next;
    logic [15:0] slew_reg,     slew_next;
    logic [15:0] clamp_reg,    clamp_next;
    logic [15:0] rdata_reg,    rdata_next;

    function automatic logic [15:0] masked(input logic [15:0] d, input logic [15:0] m);
        masked = d & m;
    endfunction : masked

    always_comb begin
        offsets_next = offsets_reg;
        osr_next     = osr_reg;
        blank_next   = blank_reg;
        slew_next    = slew_reg;
        clamp_next   = clamp_reg;
        rdata_next   = rdata_reg;
        if (cmd_wr_in) begin
            unique case (cmd_code_in)
                `CMD_VOLTAGE_OFFSETS: offsets_next = masked(cmd_wdata_in, `MASK_VOLTAGE_OFFSETS);
                `CMD_OVERSHOOT_CTRL:  osr_next     = masked(cmd_wdata_in, `MASK_OVERSHOOT_CTRL);
                `CMD_PWM_BLANKING:    blank_next   = masked(cmd_wdata_in, `MASK_PWM_BLANKING);
                `CMD_SLOPE_SLEW_2PS:  slew_next    = masked(cmd_wdata_in, `MASK_SLOPE_SLEW_2PS);
                `CMD_SLOPE_CLAMP_2PS: clamp_next   = masked(cmd_wdata_in, `MASK_SLOPE_CLAMP_2PS);
                default: begin
                end
            endcase
        end
        if (cmd_rd_in) begin
            unique case (cmd_code_in)
                `CMD_VOLTAGE_OFFSETS: rdata_next = offsets_reg;
                `CMD_OVERSHOOT_CTRL:  rdata_next = osr_reg;
                `CMD_PWM_BLANKING:    rdata_next = blank_reg;
                `CMD_SLOPE_SLEW_2PS:  rdata_next = slew_reg;
                `CMD_SLOPE_CLAMP_2PS: rdata_next = clamp_reg;
                default:              rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            offsets_reg <= `RST_VOLTAGE_OFFSETS;
            osr_reg     <= `RST_OVERSHOOT_CTRL;
            blank_reg   <= `RST_PWM_BLANKING;
            slew_reg    <= `RST_SLOPE_SLEW_2PS;
            clamp_reg   <= `RST_SLOPE_CLAMP_2PS;
            rdata_reg   <= 16'h0000;
        end else begin
            offsets_reg <= offsets_next;
            osr_reg     <= osr_next;
            blank_reg   <= blank_next;
            slew_reg    <= slew_next;
            clamp_reg   <= clamp_next;
            rdata_reg   <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Target VID
    // ------------------------------------------------------------
    logic [9:0]  vid_reg, vid_next;
    logic signed [10:0] vid_sum;
    logic        serial_mode;
    logic        offset_mode;

    always_comb begin
        serial_mode = (vid_mode_in == rail_pkg::VID_SERIAL);
        offset_mode = serial_mode || (vid_mode_in == rail_pkg::VID_PMBUS)
                      || (vid_mode_in == rail_pkg::VID_PARALLEL);
        vid_sum = $signed({3'h0, initial_vid_in});
        if (offset_mode) begin
            vid_sum = vid_sum + $signed({3'h0,
                      offsets_reg[`SPECIAL_OFS_MSB:`SPECIAL_OFS_LSB]});
        end
        if (serial_mode) begin
            vid_sum = vid_sum + 11'($signed(
                      offsets_reg[`INITIAL_OFS_MSB:`INITIAL_OFS_LSB]));
        end
        // Negative totals floor at zero rather than wrap
        vid_next = vid_sum[10] ? 10'h000 : vid_sum[9:0];
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            vid_reg <= 10'h000;
        end else begin
            vid_reg <= vid_next;
        end
    end

    // ------------------------------------------------------------
    // Overshoot flag
    // ------------------------------------------------------------
    rail_pkg::osr_state_e osr_state_reg, osr_state_next;
    logic          osr_flag_reg, osr_flag_next;
    logic          osr_tmr_start;
    logic          osr_tmr_expired;
    rail_pkg::ns_t osr_target_ns;

    always_comb begin
        osr_state_next = osr_state_reg;
        osr_tmr_start  = 1'b0;
        osr_target_ns  = 12'(osr_reg[`OSR_FILTER_MSB:`OSR_FILTER_LSB])
                         * 12'(`FILTER_NS_PER_LSB);
        if (osr_state_reg == rail_pkg::OSR_BLANK) begin
            osr_target_ns = 12'(osr_reg[`OSR_BLANK_MSB:`OSR_BLANK_LSB])
                            * 12'(`OSR_BLANK_NS_PER_LSB);
        end
        unique case (osr_state_reg)
            rail_pkg::OSR_IDLE: begin
                if (overshoot_detect_in) begin
                    osr_state_next = rail_pkg::OSR_FLAG;
                    osr_tmr_start  = 1'b1;
                end
            end
            rail_pkg::OSR_FLAG: begin
                if (osr_tmr_expired && !overshoot_detect_in) begin
                    osr_state_next = rail_pkg::OSR_BLANK;
                    osr_tmr_start  = 1'b1;
                end
            end
            rail_pkg::OSR_BLANK: begin
                if (osr_tmr_expired) begin
                    osr_state_next = rail_pkg::OSR_IDLE;
                end
            end
            default: osr_state_next = rail_pkg::OSR_IDLE;
        endcase
        if (!osr_reg[`OSR_ENABLE_BIT]) begin
            osr_state_next = rail_pkg::OSR_IDLE;
            osr_tmr_start  = 1'b0;
        end
        osr_flag_next = (osr_state_next == rail_pkg::OSR_FLAG);
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            osr_state_reg <= rail_pkg::OSR_IDLE;
            osr_flag_reg  <= 1'b0;
        end else begin
            osr_state_reg <= osr_state_next;
            osr_flag_reg  <= osr_flag_next;
        end
    end

    // Filter target at the start cycle uses the idle-state selection
    interval_timer u_osr_timer (
        .sys_clk_in   (sys_clk_in),
        .rst_n_in     (rst_n_in),
        .start_in     (osr_tmr_start),
        .target_ns_in (osr_tmr_start && osr_state_reg == rail_pkg::OSR_FLAG ?
                       12'(osr_reg[`OSR_BLANK_MSB:`OSR_BLANK_LSB]) *
                       12'(`OSR_BLANK_NS_PER_LSB) : osr_target_ns),
        .expired_out  (osr_tmr_expired)
    );

    // ------------------------------------------------------------
    // PWM spacing and slope ramp
    // ------------------------------------------------------------
    logic [1:0]    pend_reg, pend_next;
    logic [1:0]    pulse_reg, pulse_next;
    logic          slope_wait_reg, slope_wait_next;
    logic          slope_start_reg, slope_start_next;
    logic          clamp_reg_q, clamp_next_q;
    logic          clamp_run_reg, clamp_run_next;
    logic          blank_expired;
    logic          clamp_expired;
    logic          grant;
    rail_pkg::ns_t blank_ns;
    rail_pkg::ns_t clamp_ns;

    always_comb begin
        blank_ns  = 12'(blank_reg[`BLANKING_MSB:`BLANKING_LSB]) * 12'(`BLANK_NS_PER_LSB);
        clamp_ns  = 12'(clamp_reg[`SLOPE_CNT_MSB:`SLOPE_CNT_LSB]) * 12'(`CLAMP_NS_PER_LSB);
        pend_next = pend_reg | pwm_req_in;
        // Single phase has no neighbour, so no spacing is enforced
        grant      = (blank_expired || !dual_phase_in) && (pend_next != 2'b00);
        pulse_next = 2'b00;
        if (grant) begin
            pulse_next = pend_next[0] ? 2'b01 : 2'b10;
            pend_next  = pend_next & ~pulse_next;
        end
        // A grant on the expiry cycle must not swallow the ramp of the pulse before it
        slope_start_next = slope_wait_reg && blank_expired;
        slope_wait_next  = slope_wait_reg && !blank_expired;
        if (grant) begin
            slope_wait_next = 1'b1;
        end
        clamp_run_next = clamp_run_reg;
        clamp_next_q   = clamp_reg_q;
        if (grant) begin
            clamp_run_next = 1'b0;
            clamp_next_q   = 1'b0;
        end else if (slope_start_next) begin
            clamp_run_next = 1'b1;
        end else if (clamp_run_reg && clamp_expired) begin
            clamp_run_next = 1'b0;
            clamp_next_q   = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend_reg        <= 2'b00;
            pulse_reg       <= 2'b00;
            slope_wait_reg  <= 1'b0;
            slope_start_reg <= 1'b0;
            clamp_reg_q     <= 1'b0;
            clamp_run_reg   <= 1'b0;
        end else begin
            pend_reg        <= pend_next;
            pulse_reg       <= pulse_next;
            slope_wait_reg  <= slope_wait_next;
            slope_start_reg <= slope_start_next;
            clamp_reg_q     <= clamp_next_q;
            clamp_run_reg   <= clamp_run_next;
        end
    end

    interval_timer u_blank_timer (
        .sys_clk_in   (sys_clk_in),
        .rst_n_in     (rst_n_in),
        .start_in     (grant),
        .target_ns_in (blank_ns),
        .expired_out  (blank_expired)
    );

    interval_timer u_clamp_timer (
        .sys_clk_in   (sys_clk_in),
        .rst_n_in     (rst_n_in),
        .start_in     (slope_start_next),
        .target_ns_in (clamp_ns),
        .expired_out  (clamp_expired)
    );

    // ------------------------------------------------------------
    // Slope setting select
    // ------------------------------------------------------------
    logic [5:0] cur_reg, cur_next;
    logic [3:0] cap_reg, cap_next;

    always_comb begin
        cur_next = other_slope_current_in;
        cap_next = other_slope_cap_in;
        if (two_phase_ccm_in) begin
            cur_next = slew_reg[`SLOPE_CUR_MSB:`SLOPE_CUR_LSB];
            cap_next = slew_reg[`SLOPE_CAP_MSB:`SLOPE_CAP_LSB];
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cur_reg <= 6'h00;
            cap_reg <= 4'h0;
        end else begin
            cur_reg <= cur_next;
            cap_reg <= cap_next;
        end
    end

    assign cmd_rdata_out     = rdata_reg;
    assign target_vid_out    = vid_reg;
    assign osr_flag_out      = osr_flag_reg;
    assign pwm_pulse_out     = pulse_reg;
    assign slope_start_out   = slope_start_reg;
    assign slope_clamp_out   = clamp_reg_q;
    assign slope_current_out = cur_reg;
    assign slope_cap_out     = cap_reg;

endmodule : rail_offset_pwm_timing_config

// File: hdl/rail_defines.svh
`ifndef RAIL_DEFINES_SVH
`define RAIL_DEFINES_SVH

// ------------------------------------------------------------
// Command codes
// ------------------------------------------------------------
`define CMD_VOLTAGE_OFFSETS   8'hDF
`define CMD_OVERSHOOT_CTRL    8'hE0
`define CMD_PWM_BLANKING      8'hE1
`define CMD_SLOPE_SLEW_2PS    8'hE2
`define CMD_SLOPE_CLAMP_2PS   8'hE3

// ------------------------------------------------------------
// Writable bit masks
// ------------------------------------------------------------
`define MASK_VOLTAGE_OFFSETS  16'h7FFF
`define MASK_OVERSHOOT_CTRL   16'h3FBF
`define MASK_PWM_BLANKING     16'h003F
`define MASK_SLOPE_SLEW_2PS   16'h03FF
`define MASK_SLOPE_CLAMP_2PS  16'h01FF

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_VOLTAGE_OFFSETS   16'h0000
`define RST_OVERSHOOT_CTRL    16'h0000
`define RST_PWM_BLANKING      16'h0000
`define RST_SLOPE_SLEW_2PS    16'h0000
`define RST_SLOPE_CLAMP_2PS   16'h0000

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define SPECIAL_OFS_MSB       14
`define SPECIAL_OFS_LSB       7
`define INITIAL_OFS_MSB       6
`define INITIAL_OFS_LSB       0
`define OSR_ENABLE_BIT        13
`define OSR_BLANK_MSB         12
`define OSR_BLANK_LSB         7
`define OSR_FILTER_MSB        5
`define OSR_FILTER_LSB        0
`define BLANKING_MSB          5
`define BLANKING_LSB          0
`define SLOPE_CAP_MSB         9
`define SLOPE_CAP_LSB         6
`define SLOPE_CUR_MSB         5
`define SLOPE_CUR_LSB         0
`define SLOPE_CNT_MSB         8
`define SLOPE_CNT_LSB         0

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS         25
`define FILTER_NS_PER_LSB     5
`define OSR_BLANK_NS_PER_LSB  20
`define BLANK_NS_PER_LSB      5
`define CLAMP_NS_PER_LSB      5
`define TIMER_NS_WIDTH        12

`endif

// File: hdl/rail_pkg.sv
package rail_pkg;

    typedef enum logic [1:0] {
        VID_SERIAL,
        VID_PMBUS,
        VID_PARALLEL,
        VID_RESERVED
    } vid_mode_e;

    typedef enum logic [1:0] {
        OSR_IDLE,
        OSR_FLAG,
        OSR_BLANK
    } osr_state_e;

    typedef logic [11:0] ns_t;

endpackage : rail_pkg

// File: hdl/interval_timer.sv
`timescale 1ns/100ps
`include "rail_defines.svh"

module interval_timer (
    input  wire logic          sys_clk_in,
    input  wire logic          rst_n_in,
    input  wire logic          start_in,
    input  wire rail_pkg::ns_t target_ns_in,
    output logic               expired_out
);

    // Time kept in ns so 5 ns steps round up at the 25 ns clock
    rail_pkg::ns_t elapsed_reg;
    rail_pkg::ns_t elapsed_next;
    logic          expired_reg;
    logic          expired_next;
    logic [12:0]   sum;

    always_comb begin
        sum          = 13'(elapsed_reg) + 13'(`CLK_PERIOD_NS);
        elapsed_next = elapsed_reg;
        expired_next = expired_reg;
        if (start_in) begin
            elapsed_next = 12'(`CLK_PERIOD_NS);
            expired_next = (12'(`CLK_PERIOD_NS) >= target_ns_in);
        end else if (!expired_reg) begin
            elapsed_next = sum[12] ? 12'hFFF : sum[11:0];
            expired_next = (elapsed_next >= target_ns_in);
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            elapsed_reg <= 12'h000;
            expired_reg <= 1'b1;
        end else begin
            elapsed_reg <= elapsed_next;
            expired_reg <= expired_next;
        end
    end

    assign expired_out = expired_reg;

endmodule : interval_timer

// File: sim/rail_sim_pkg.sv
package rail_sim_pkg;

    // ----------------
    // Readable bits
    // ----------------
    // Unmapped codes read as all zero
    function automatic logic [15:0] rmask(input logic [7:0] c);
        case (c)
            8'hDF: rmask = 16'h7FFF;
            8'hE0: rmask = 16'h3FBF;
            8'hE1: rmask = 16'h003F;
            8'hE2: rmask = 16'h03FF;
            8'hE3: rmask = 16'h01FF;
            default: rmask = 16'h0000;
        endcase
    endfunction : rmask

endpackage : rail_sim_pkg

// File: sim/rail_cfg_properties.sv
`timescale 1ns/100ps
module rail_cfg_checker (
    input wire logic        sys_clk_in,
    input wire logic        rst_n_in,
    input wire logic [7:0]  cmd_code_in,
    input wire logic        cmd_wr_in,
    input wire logic        cmd_rd_in,
    input wire logic [15:0] cmd_wdata_in,
    input wire logic        overshoot_detect_in,
    input wire logic        dual_phase_in,
    input wire logic        two_phase_ccm_in,
    input wire logic [5:0]  other_slope_current_in,
    input wire logic [3:0]  other_slope_cap_in,
    input wire logic [15:0] cmd_rdata_out,
    input wire logic        osr_flag_out,
    input wire logic [1:0]  pwm_pulse_out,
    input wire logic        slope_clamp_out,
    input wire logic [5:0]  slope_current_out,
    input wire logic [3:0]  slope_cap_out
);
    // ----------------
    // Shadow state
    // ----------------
    logic       overshoot_reduce_enable_reg, overshoot_reduce_enable_next;
    logic [5:0] blank_reg, blank_next;
    logic [6:0] gap_reg, gap_next, need;

    always_comb begin
        overshoot_reduce_enable_next = (cmd_wr_in && cmd_code_in == 8'hE0) ? cmd_wdata_in[13] : overshoot_reduce_enable_reg;
        blank_next  = (cmd_wr_in && cmd_code_in == 8'hE1) ? cmd_wdata_in[5:0] : blank_reg;
        gap_next    = (pwm_pulse_out != 2'h0) ? 7'h01 : gap_reg + {6'h00, gap_reg != 7'h7F};
        // Whole cycles rounded up, one at least
        need = (blank_reg < 6'h05) ? 7'h01 : ({1'b0, blank_reg} + 7'h04) / 7'h05;
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            overshoot_reduce_enable_reg <= 1'b0;
            blank_reg  <= 6'h00;
            gap_reg    <= 7'h7F;
        end else begin
            overshoot_reduce_enable_reg <= overshoot_reduce_enable_next;
            blank_reg  <= blank_next;
            gap_reg    <= gap_next;
        end
    end

    // ----------------
    // Properties
    // ----------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    rd_unused_zero_a: assert property (
        $past(cmd_rd_in) |-> (cmd_rdata_out & ~rail_sim_pkg::rmask($past(cmd_code_in))) == 16'h0)
        else $error("read data has unused bits set");
    flag_cause_a: assert property (
        $rose(osr_flag_out) |-> $past(overshoot_detect_in) && $past(overshoot_reduce_enable_reg))
        else $error("flag rose without enabled detect");
    flag_hold_a: assert property (
        osr_flag_out && overshoot_detect_in && overshoot_reduce_enable_reg && !cmd_wr_in |=> osr_flag_out)
        else $error("flag dropped while detect high");
    flag_blank_a: assert property (
        $fell(osr_flag_out) |=> !osr_flag_out)
        else $error("flag re-armed without blanking");
    osr_off_a: assert property (
        !overshoot_reduce_enable_reg && !$past(overshoot_reduce_enable_reg) |-> !osr_flag_out)
        else $error("flag high while disabled");
    pulse_onehot_a: assert property (
        $onehot0(pwm_pulse_out))
        else $error("two phases pulsed together");
    pulse_gap_a: assert property (
        pwm_pulse_out != 2'h0 && $past(dual_phase_in) |-> gap_reg >= need)
        else $error("pulses closer than blanking");
    clamp_clear_a: assert property (
        pwm_pulse_out != 2'h0 |-> !slope_clamp_out)
        else $error("clamp still set at new pulse");
    slope_other_a: assert property (
        !two_phase_ccm_in |=> slope_current_out == $past(other_slope_current_in)
            && slope_cap_out == $past(other_slope_cap_in))
        else $error("slope setting not from active state");

    cover property ($rose(osr_flag_out));
    cover property ($rose(slope_clamp_out));
    cover property (pwm_pulse_out == 2'h2 && $past(dual_phase_in));
endmodule : rail_cfg_checker

bind rail_offset_pwm_timing_config rail_cfg_checker u_chk (
    .sys_clk_in, .rst_n_in, .cmd_code_in, .cmd_wr_in, .cmd_rd_in, .cmd_wdata_in,
    .overshoot_detect_in, .dual_phase_in, .two_phase_ccm_in, .other_slope_current_in,
    .other_slope_cap_in, .cmd_rdata_out, .osr_flag_out, .pwm_pulse_out, .slope_clamp_out,
    .slope_current_out, .slope_cap_out
);

// File: sim/test_rail_offset_pwm_timing_config.sv
`timescale 1ns/100ps
module test_rail_offset_pwm_timing_config;
    logic        sys_clk_in = 1'b0, rst_n_in = 1'b0, cmd_wr_in = 1'b0, cmd_rd_in = 1'b0;
    logic        overshoot_detect_in = 1'b0, dual_phase_in = 1'b0, two_phase_ccm_in = 1'b0;
    logic [7:0]  cmd_code_in = 8'h00, initial_vid_in = 8'h00;
    logic [15:0] cmd_wdata_in = 16'h0000, cmd_rdata_out;
    logic [1:0]  vid_mode_in = 2'h0, pwm_req_in = 2'h0, pwm_pulse_out;
    logic [5:0]  other_slope_current_in = 6'h00, slope_current_out;
    logic [3:0]  other_slope_cap_in = 4'h0, slope_cap_out;
    logic [9:0]  target_vid_out;
    logic        osr_flag_out, slope_start_out, slope_clamp_out;
    int          checks = 0;
    int          n_mismatch = 0;

    rail_offset_pwm_timing_config u_dut (
        .sys_clk_in, .rst_n_in, .cmd_code_in, .cmd_wr_in, .cmd_rd_in, .cmd_wdata_in,
        .vid_mode_in, .initial_vid_in, .overshoot_detect_in, .dual_phase_in,
        .two_phase_ccm_in, .pwm_req_in, .other_slope_current_in, .other_slope_cap_in,
        .cmd_rdata_out, .target_vid_out, .osr_flag_out, .pwm_pulse_out,
        .slope_start_out, .slope_clamp_out, .slope_current_out, .slope_cap_out
    );

    always #12.5 sys_clk_in = ~sys_clk_in;

    // ----------------
    // Helpers
    // ----------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : chk

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask : settle

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge sys_clk_in);
        cmd_code_in  <= c;
        cmd_wdata_in <= d;
        cmd_wr_in    <= 1'b1;
        @(posedge sys_clk_in);
        cmd_wr_in    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] c, output logic [15:0] v);
        @(posedge sys_clk_in);
        cmd_code_in <= c;
        cmd_rd_in   <= 1'b1;
        @(posedge sys_clk_in);
        cmd_rd_in   <= 1'b0;
        settle(1);
        v = cmd_rdata_out;
    endtask : rd

    // Starts and ends on an edge, so flag-high cycles count exactly
    task automatic count_flag(input int n, output int w);
        w = 0;
        repeat (n) begin
            #1;
            if (osr_flag_out === 1'b1) w++;
            @(posedge sys_clk_in);
        end
    endtask : count_flag

    function automatic logic [9:0] exp_vid(input logic [7:0] iv, input logic [15:0] r,
                                           input logic [1:0] m);
        int t;
        t = int'(iv);
        if (m != 2'h3) t = t + int'(r[14:7]);
        if (m == 2'h0) t = t + int'($signed(r[6:0]));
        exp_vid = (t < 0) ? 10'h000 : 10'(t);
    endfunction : exp_vid

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // ----------------
    // Sequence
    // ----------------
    initial begin
        logic [15:0] v, d;
        logic [7:0]  codes [6];
        logic [7:0]  iv;
        int          w, n, need, t0, t1, ts, tc;
        void'($urandom(32'hE33A));
        codes = '{8'hDF, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hD0};
        repeat (6) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        foreach (codes[i]) begin
            rd(codes[i], v);
            chk(v, 16'h0000);
            for (int j = 0; j < 2; j++) begin
                d = (j == 0) ? 16'hFFFF : 16'($urandom);
                wr(codes[i], d);
                rd(codes[i], v);
                chk(v, d & rail_sim_pkg::rmask(codes[i]));
            end
        end
        // Floor at zero and widest sum first, then random
        for (int i = 0; i < 16; i++) begin
            d  = (i < 4) ? 16'h0040 : (i < 8) ? 16'h7FBF : 16'($urandom);
            iv = (i < 4) ? 8'h10 : (i < 8) ? 8'hFF : 8'($urandom);
            wr(8'hDF, d);
            vid_mode_in    <= 2'(i);
            initial_vid_in <= iv;
            settle(3);
            chk(16'(target_vid_out), 16'(exp_vid(iv, d, 2'(i))));
        end
        for (int i = 0; i < 8; i++) begin
            d = 16'($urandom);
            wr(8'hE2, d);
            two_phase_ccm_in       <= i[0];
            other_slope_current_in <= 6'($urandom);
            other_slope_cap_in     <= 4'($urandom);
            settle(3);
            d = i[0] ? 16'(d[9:0]) : 16'({other_slope_cap_in, other_slope_current_in});
            chk(16'({slope_cap_out, slope_current_out}), d);
        end
        // Filter 100 ns, blanking 200 ns
        wr(8'hE0, 16'h2514);
        @(posedge sys_clk_in);
        overshoot_detect_in <= 1'b1;
        @(posedge sys_clk_in);
        overshoot_detect_in <= 1'b0;
        count_flag(8, w);
        chk(16'(w >= 4 && w <= 5), 16'h0001);
        overshoot_detect_in <= 1'b1;
        count_flag(3, w);
        chk(16'(w), 16'h0000);
        count_flag(12, w);
        chk(16'(w >= 6), 16'h0001);
        wr(8'hE0, 16'h0514);
        // Flag drops one cycle after the disabling write lands
        @(posedge sys_clk_in);
        count_flag(6, w);
        chk(16'(w), 16'h0000);
        overshoot_detect_in <= 1'b0;
        // Clamp after 100 ns; both phases requested together
        wr(8'hE3, 16'h0014);
        for (int r = 0; r < 3; r++) begin
            n    = (r == 0) ? 30 : int'($urandom_range(63, 17));
            need = (n + 4) / 5;
            wr(8'hE1, 16'(n));
            dual_phase_in <= (r != 2);
            @(posedge sys_clk_in);
            pwm_req_in <= 2'h3;
            @(posedge sys_clk_in);
            pwm_req_in <= 2'h0;
            t0 = -100;
            t1 = -100;
            ts = -100;
            for (int k = 0; k < 48; k++) begin
                #1;
                if (pwm_pulse_out[0] === 1'b1) t0 = k;
                if (pwm_pulse_out[1] === 1'b1) t1 = k;
                if (slope_start_out === 1'b1 && ts < 0) ts = k;
                if (slope_clamp_out !== 1'b1) tc = k + 1;
                @(posedge sys_clk_in);
            end
            w = (r == 2) ? 1 : need;
            chk(16'(t1 - t0 >= w && t1 - t0 <= w + ((r == 2) ? 0 : 2)), 16'h0001);
            chk(16'(ts - t0 >= need - 1 && ts - t0 <= need + 2), 16'h0001);
            chk(16'(tc > t1 && tc < 48), 16'h0001);
        end
        tally_and_finish();
    end

    // Sequence takes about 400 cycles; fifty times that means a hang
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        n_mismatch++;
        tally_and_finish();
    end
endmodule : test_rail_offset_pwm_timing_config
